// File: rtl/gst_timer.sv
// gated sixteen-bit timer/counter with gate unit and register port
// assumes a one-clock system; pins and comparators are asynchronous
//
// Behaviour
// - byte reads each return a coherent byte; the two count bytes are not latched together
// - gated: count on tick when gate active
// - polarity bit picks active gate level
// - source field picks pin, wrap, comparators
// - byte timer wrap makes one gate pulse
// - toggle flop flips on rising edges, cleared when toggle mode or timer off
// - go bit arms capture from next edge
// - trailing edge clears go, blocks further counting
// - toggle and single pulse work together
// - gate status always shows gate level
// - gate status falling edge sets event flag
// - rollover sets sticky overflow flag
// - overflow irq needs on and three enables
// - sleep counts only unsynchronised external mode
// - external mode needs falling edge first
// - clock field picks instr, sys, ext, lfosc
// - prescale field divides by 1/2/4/8
// - off clears gate flop; sync bit setting
// - off, always-on, or gate-controlled counting
// - gate_control bit layout
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module gst_timer
    import gst_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_external_clock_pin,
    input  wire logic       i_low_freq_internal_osc,
    input  wire logic       i_external_gate_pin,
    input  wire logic       i_comparator_one_output,
    input  wire logic       i_comparator_two_output,
    input  wire logic [7:0] i_byte_timer_count,
    input  wire logic       i_peripheral_irq_enable,
    input  wire logic       i_global_irq_enable,
    input  wire logic       i_sleep,
    output logic            o_overflow_irq,
    output logic            o_gate_irq,
    output logic            o_wake
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0]   count_ff;
    logic [7:0]    tctrl_ff;
    logic [7:0]    gctrl_ff;
    logic          go_ff;
    logic          ovf_flag_ff;
    logic          gate_flag_ff;
    logic [1:0]    irq_en_ff;
    logic [7:0]    rdata_ff;
    logic [1:0]    instr_div_ff;
    logic          ext_d_ff;
    logic          lf_d_ff;
    logic          ext_arm_ff;
    logic [7:0]    byte_d_ff;
    logic          tog_ff;
    logic          tog_src_d_ff;
    logic          gval_ff;
    gst_sp_state_t sp_ff;

    logic [4:0]    pin_sync;
    logic          wr_lo;
    logic          wr_hi;
    logic          wr_gc;
    logic          on;
    logic [1:0]    cs;
    logic          wrap_pulse;
    logic          gsrc;
    logic          gact;
    logic          tog_out;
    logic          gate_now;
    logic          raw_tick;
    logic          tick;
    logic          sleep_ok;
    logic          inc;
    logic [15:0]   nxt_count;

    assign wr_lo = i_wr && (i_addr == GST_OFF_CNT_LO);
    assign wr_hi = i_wr && (i_addr == GST_OFF_CNT_HI);
    assign wr_gc = i_wr && (i_addr == GST_OFF_GCTRL);
    assign on    = tctrl_ff[GST_TC_ON_BIT];
    assign cs    = tctrl_ff[GST_TC_CS_LSB +: 2];

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    gst_sync2 #(.W(5)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_async   ({i_low_freq_internal_osc, i_comparator_two_output,
                     i_comparator_one_output, i_external_gate_pin, i_external_clock_pin}),
        .o_sync    (pin_sync)
    );

    // ************************************************************
    // clock source and prescale
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            instr_div_ff <= 2'h0;
            ext_d_ff     <= 1'b0;
            lf_d_ff      <= 1'b0;
        end else begin
            instr_div_ff <= instr_div_ff + 2'h1;
            ext_d_ff     <= pin_sync[0];
            lf_d_ff      <= pin_sync[4];
        end
    end

    // a high pin at enable or after a write must not count at once
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_arm_ff <= 1'b0;
        end else if (!on || wr_lo || wr_hi) begin
            ext_arm_ff <= 1'b0;
        end else if (ext_d_ff && !pin_sync[0]) begin
            ext_arm_ff <= 1'b1;
        end
    end

    // the slow oscillator is another clock, so it passes the synchroniser too
    always_comb begin
        case (cs)
            GST_CS_INSTR: raw_tick = (instr_div_ff == GST_INSTR_LAST);
            GST_CS_SYS:   raw_tick = 1'b1;
            GST_CS_EXT:   raw_tick = pin_sync[0] && !ext_d_ff && ext_arm_ff;
            GST_CS_LFOSC: raw_tick = pin_sync[4] && !lf_d_ff;
            default:      raw_tick = 1'b0;
        endcase
    end

    gst_prescale u_presc (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_tick    (raw_tick),
        .i_clear   (wr_lo || wr_hi),
        .i_sel     (tctrl_ff[GST_TC_PS_LSB +: 2]),
        .o_tick    (tick)
    );

    // ************************************************************
    // gate source and conditioning
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            byte_d_ff <= 8'h00;
        end else begin
            byte_d_ff <= i_byte_timer_count;
        end
    end

    assign wrap_pulse = (byte_d_ff == 8'hff) && (i_byte_timer_count == 8'h00);

    always_comb begin
        case (gctrl_ff[GST_GC_SS_LSB +: 2])
            GST_GS_PIN:  gsrc = pin_sync[1];
            GST_GS_WRAP: gsrc = wrap_pulse;
            GST_GS_CMP1: gsrc = pin_sync[2];
            GST_GS_CMP2: gsrc = pin_sync[3];
            default:     gsrc = 1'b0;
        endcase
    end

    // polarity first so the toggle flop sees the counting edge
    assign gact = gctrl_ff[GST_GC_POL_BIT] ? gsrc : !gsrc;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tog_ff       <= 1'b0;
            tog_src_d_ff <= 1'b0;
        end else begin
            tog_src_d_ff <= gact;
            if (!gctrl_ff[GST_GC_TM_BIT] || !on) begin
                tog_ff <= 1'b0;
            end else if (gact && !tog_src_d_ff) begin
                tog_ff <= !tog_ff;
            end
        end
    end

    assign tog_out = gctrl_ff[GST_GC_TM_BIT] ? tog_ff : gact;

    // ************************************************************
    // single-pulse capture
    // ************************************************************
    // toggle output feeds this unchanged, so both modes stack
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sp_ff <= GST_SP_IDLE;
        end else begin
            case (sp_ff)
                GST_SP_IDLE: begin
                    if (go_ff && !tog_out) begin
                        sp_ff <= GST_SP_ARM;
                    end
                end
                GST_SP_ARM: begin
                    if (!go_ff) begin
                        sp_ff <= GST_SP_IDLE;
                    end else if (tog_out) begin
                        sp_ff <= GST_SP_RUN;
                    end
                end
                GST_SP_RUN: begin
                    if (!go_ff || !tog_out) begin
                        sp_ff <= GST_SP_IDLE;
                    end
                end
                default: sp_ff <= GST_SP_IDLE;
            endcase
        end
    end

    always_comb begin
        if (gctrl_ff[GST_GC_SPM_BIT]) begin
            gate_now = go_ff && tog_out && (sp_ff != GST_SP_IDLE);
        end else begin
            gate_now = tog_out;
        end
    end

    // ************************************************************
    // gate status and counter
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gval_ff <= 1'b0;
        end else begin
            gval_ff <= gate_now;
        end
    end

    assign sleep_ok = !i_sleep || (cs == GST_CS_EXT && tctrl_ff[GST_TC_SYNC_BIT]);
    assign inc = on && tick && sleep_ok
              && (!gctrl_ff[GST_GC_GE_BIT] || gval_ff);

    // a byte write beats a coincident increment; stop first to be safe
    always_comb begin
        nxt_count = count_ff;
        if (inc) begin
            nxt_count = count_ff + 16'h0001;
        end
        if (wr_lo) begin
            nxt_count[7:0] = i_wdata;
        end
        if (wr_hi) begin
            nxt_count[15:8] = i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_ff <= 16'h0000;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ************************************************************
    // control registers and flags
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tctrl_ff  <= GST_REG_RST;
            gctrl_ff  <= GST_REG_RST;
            irq_en_ff <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == GST_OFF_TCTRL) begin
                tctrl_ff <= i_wdata & GST_TC_WMASK;
            end
            if (wr_gc) begin
                gctrl_ff <= i_wdata;
            end
            if (i_addr == GST_OFF_IRQ_EN) begin
                irq_en_ff <= i_wdata[1:0];
            end
        end
    end

    // software set of go wins over the hardware clear
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            go_ff <= 1'b0;
        end else if (wr_gc) begin
            go_ff <= i_wdata[GST_GC_GO_BIT];
        end else if (sp_ff == GST_SP_RUN && !tog_out) begin
            go_ff <= 1'b0;
        end
    end

    // write-one-to-clear; a same-cycle event keeps the flag set
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ovf_flag_ff  <= 1'b0;
            gate_flag_ff <= 1'b0;
        end else begin
            if (inc && count_ff == GST_CNT_MAX) begin
                ovf_flag_ff <= 1'b1;
            end else if (i_wr && i_addr == GST_OFF_FLAGS && i_wdata[GST_FL_OVF_BIT]) begin
                ovf_flag_ff <= 1'b0;
            end
            if (gval_ff && !gate_now) begin
                gate_flag_ff <= 1'b1;
            end else if (i_wr && i_addr == GST_OFF_FLAGS && i_wdata[GST_FL_GATE_BIT]) begin
                gate_flag_ff <= 1'b0;
            end
        end
    end

    assign o_overflow_irq = ovf_flag_ff && on && irq_en_ff[GST_FL_OVF_BIT]
                         && i_peripheral_irq_enable && i_global_irq_enable;
    assign o_gate_irq = gate_flag_ff && irq_en_ff[GST_FL_GATE_BIT];
    assign o_wake = i_sleep && ovf_flag_ff && on && irq_en_ff[GST_FL_OVF_BIT]
                 && i_peripheral_irq_enable;

    // ************************************************************
    // read port
    // ************************************************************
    // the count lives in this domain, so each byte read is coherent
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_ff <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                GST_OFF_CNT_LO: rdata_ff <= count_ff[7:0];
                GST_OFF_CNT_HI: rdata_ff <= count_ff[15:8];
                GST_OFF_TCTRL:  rdata_ff <= tctrl_ff;
                GST_OFF_GCTRL:  rdata_ff <= {gctrl_ff[7:4], go_ff, gval_ff,
                                             gctrl_ff[1:0]};
                GST_OFF_FLAGS:  rdata_ff <= {6'h00, gate_flag_ff, ovf_flag_ff};
                GST_OFF_IRQ_EN: rdata_ff <= {6'h00, irq_en_ff};
                default:        rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign o_rdata = rdata_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_capture_end;
        sp_ff == GST_SP_RUN && !tog_out && !wr_gc;
    endsequence

    a_ovf_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        inc && count_ff == GST_CNT_MAX && !wr_lo && !wr_hi |=> ovf_flag_ff && count_ff == 16'h0000)
        else $error("rollover did not set overflow flag");
    a_ovf_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_overflow_irq |-> on && irq_en_ff[0] && i_peripheral_irq_enable && i_global_irq_enable)
        else $error("overflow irq without all enables");
    a_gate_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        gctrl_ff[GST_GC_GE_BIT] && !gval_ff && !wr_lo && !wr_hi |=> $stable(count_ff))
        else $error("count moved while gate inactive");
    a_off_stable: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !on && !wr_lo && !wr_hi |=> count_ff == $past(count_ff))
        else $error("count moved while off");
    a_toggle_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !gctrl_ff[GST_GC_TM_BIT] || !on |=> !tog_ff)
        else $error("toggle flop not held clear");
    a_gate_event: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        gval_ff && !gate_now |=> gate_flag_ff)
        else $error("gate falling edge lost");
    a_go_done: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        s_capture_end |=> !go_ff ##1 (!go_ff || $past(wr_gc)))
        else $error("go not cleared at pulse end");
    a_ext_arm: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        cs == GST_CS_EXT && !ext_arm_ff && !wr_lo && !wr_hi |=> $stable(count_ff))
        else $error("external count before falling edge");
    a_wrap_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wrap_pulse |=> !wrap_pulse)
        else $error("wrap pulse longer than one cycle");
    a_read_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_rd && i_addr == GST_OFF_CNT_LO |=> o_rdata == $past(count_ff[7:0]))
        else $error("low byte read not coherent");
    a_wake_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_wake |-> i_sleep && on && ovf_flag_ff)
        else $error("wake without sleep overflow");

endmodule

// File: rtl/gst_pkg.sv
// constants shared by the gated sixteen-bit timer files
// assumes an 8-bit register port with a 3-bit word address
package gst_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [2:0] GST_OFF_CNT_LO  = 3'h0;
    localparam logic [2:0] GST_OFF_CNT_HI  = 3'h1;
    localparam logic [2:0] GST_OFF_TCTRL   = 3'h2;
    localparam logic [2:0] GST_OFF_GCTRL   = 3'h3;
    localparam logic [2:0] GST_OFF_FLAGS   = 3'h4;
    localparam logic [2:0] GST_OFF_IRQ_EN  = 3'h5;

    // ************************************************************
    // timer_control fields
    // ************************************************************
    localparam int GST_TC_CS_LSB   = 6;
    localparam int GST_TC_PS_LSB   = 4;
    localparam int GST_TC_SYNC_BIT = 2;
    localparam int GST_TC_ON_BIT   = 0;
    localparam logic [7:0] GST_TC_WMASK = 8'hf5;

    // ************************************************************
    // gate_control fields
    // ************************************************************
    localparam int GST_GC_GE_BIT   = 7;
    localparam int GST_GC_POL_BIT  = 6;
    localparam int GST_GC_TM_BIT   = 5;
    localparam int GST_GC_SPM_BIT  = 4;
    localparam int GST_GC_GO_BIT   = 3;
    localparam int GST_GC_VAL_BIT  = 2;
    localparam int GST_GC_SS_LSB   = 0;

    // ************************************************************
    // flag and enable bits
    // ************************************************************
    localparam int GST_FL_OVF_BIT  = 0;
    localparam int GST_FL_GATE_BIT = 1;

    // ************************************************************
    // encodings and reset values
    // ************************************************************
    localparam logic [1:0] GST_CS_INSTR = 2'h0;
    localparam logic [1:0] GST_CS_SYS   = 2'h1;
    localparam logic [1:0] GST_CS_EXT   = 2'h2;
    localparam logic [1:0] GST_CS_LFOSC = 2'h3;
    localparam logic [1:0] GST_GS_PIN   = 2'h0;
    localparam logic [1:0] GST_GS_WRAP  = 2'h1;
    localparam logic [1:0] GST_GS_CMP1  = 2'h2;
    localparam logic [1:0] GST_GS_CMP2  = 2'h3;
    localparam logic [7:0] GST_REG_RST  = 8'h00;
    localparam logic [1:0] GST_INSTR_LAST = 2'h3;
    localparam logic [15:0] GST_CNT_MAX = 16'hffff;

    typedef enum logic [2:0] {
        GST_SP_IDLE = 3'b001,
        GST_SP_ARM  = 3'b010,
        GST_SP_RUN  = 3'b100
    } gst_sp_state_t;

endpackage

// File: rtl/gst_sync2.sv
// two-flop level synchroniser, one per bit
// assumes inputs are asynchronous to i_sys_clk
`timescale 1ns/1ps
module gst_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

// File: rtl/gst_prescale.sv
// divide-by-1/2/4/8 tick prescaler
// assumes i_tick is a one-cycle pulse on i_sys_clk
`timescale 1ns/1ps
module gst_prescale
    import gst_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_tick,
    input  wire logic       i_clear,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);
    logic [2:0] cnt_ff;
    logic [2:0] mask;

    always_comb begin
        case (i_sel)
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    // clear wins so a count write restarts the division
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff <= 3'h0;
        end else if (i_clear) begin
            cnt_ff <= 3'h0;
        end else if (i_tick) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    assign o_tick = i_tick && ((cnt_ff & mask) == mask) && !i_clear;
endmodule

// File: dv/gst_far_side.sv
// far-side model: count clock, slow oscillator, gate pin, comparators, byte timer
// assumes the bench steers the gate level just after rising edges of i_sys_clk
`timescale 1ns/1ps
module gst_far_side (
    input  wire logic       i_sys_clk,
    input  wire logic       i_gate_cmd,
    output logic            o_ext_clk,
    output logic            o_osc,
    output logic            o_gate,
    output logic            o_cmp1,
    output logic            o_cmp2,
    output logic [7:0]      o_byte_cnt
);
    // ************************************************************
    // free-running clocks
    // ************************************************************
    // a counting clock, not a framed link, so it runs free
    logic [3:0] div_ff  = 4'h0;
    logic [7:0] byte_ff = 8'h00;
    always_ff @(posedge i_sys_clk) begin
        div_ff  <= div_ff + 4'h1;
        byte_ff <= byte_ff + 8'h01;
    end
    assign o_ext_clk  = div_ff[2];
    assign o_osc      = div_ff[3];
    assign o_byte_cnt = byte_ff;
    // ************************************************************
    // gate sources
    // ************************************************************
    // comparator two is the inverse so one level tells both codes apart
    assign o_gate = i_gate_cmd;
    assign o_cmp1 = i_gate_cmd;
    assign o_cmp2 = ~i_gate_cmd;
endmodule

// File: dv/tb.sv
// self-checking bench for the gated sixteen-bit timer
// assumes a single 200 MHz clock and the register map of gst_pkg
`timescale 1ns/1ps
module tb
    import gst_pkg::*;
;
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, gate = 1'b0;
    logic i_peripheral_irq_enable = 1'b0, i_global_irq_enable = 1'b0, i_sleep = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, bcnt, v0, v1;
    logic ext, osc, gpin, c1, c2, o_overflow_irq, o_gate_irq, o_wake;
    int   fails = 0, checks = 0;
    typedef struct { logic [7:0] tc, gc; logic g, sl; logic [7:0] d; } gst_row_t;
    gst_row_t rows[19] = '{
        '{8'h41,8'h00,0,0,8'h40}, '{8'h51,8'h00,0,0,8'h20}, '{8'h61,8'h00,0,0,8'h10},
        '{8'h71,8'h00,0,0,8'h08}, '{8'h01,8'h00,0,0,8'h10}, '{8'h31,8'h00,0,0,8'h02},
        '{8'hc1,8'h00,0,0,8'h04}, '{8'hd1,8'h00,0,0,8'h02}, '{8'h81,8'h00,0,0,8'h08},
        '{8'h40,8'h00,0,0,8'h00}, '{8'h41,8'hc0,0,0,8'h00}, '{8'h41,8'hc0,1,0,8'h40},
        '{8'h41,8'h80,0,0,8'h40}, '{8'h41,8'h80,1,0,8'h00}, '{8'h41,8'hc2,1,0,8'h40},
        '{8'h41,8'hc3,1,0,8'h00}, '{8'h41,8'he0,1,0,8'h40}, '{8'h41,8'h00,0,1,8'h00},
        '{8'h85,8'h00,0,1,8'h08}};

    always #2.5 i_sys_clk = ~i_sys_clk;

    gst_far_side u_far (.i_sys_clk(i_sys_clk), .i_gate_cmd(gate), .o_ext_clk(ext),
        .o_osc(osc), .o_gate(gpin), .o_cmp1(c1), .o_cmp2(c2), .o_byte_cnt(bcnt));
    gst_timer dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_external_clock_pin(ext), .i_low_freq_internal_osc(osc),
        .i_external_gate_pin(gpin), .i_comparator_one_output(c1),
        .i_comparator_two_output(c2), .i_byte_timer_count(bcnt),
        .i_peripheral_irq_enable(i_peripheral_irq_enable),
        .i_global_irq_enable(i_global_irq_enable), .i_sleep(i_sleep),
        .o_overflow_irq(o_overflow_irq), .o_gate_irq(o_gate_irq), .o_wake(o_wake));

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    // read data are sampled once the answering edge has landed
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge i_sys_clk);
        fails++;
        end_sim;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        rd(GST_OFF_TCTRL, v0);
        chk("tctrl reset", 8'h00, v0);
        wr(GST_OFF_TCTRL, 8'hff);
        rd(GST_OFF_TCTRL, v0);
        chk("tctrl mask", 8'hf5, v0);
        rd(3'h6, v0);
        chk("unmapped", 8'h00, v0);
        // a source switch to a high level is an edge, so the toggle row counts
        foreach (rows[i]) begin
            wr(GST_OFF_TCTRL, rows[i].tc);
            wr(GST_OFF_GCTRL, rows[i].gc);
            gate <= rows[i].g;
            i_sleep <= rows[i].sl;
            repeat (16) @(posedge i_sys_clk);
            rd(GST_OFF_CNT_LO, v0);
            repeat (62) @(posedge i_sys_clk);
            rd(GST_OFF_CNT_LO, v1);
            chk($sformatf("row %0d", i), rows[i].d, v1 - v0);
        end
        @(posedge i_sys_clk);
        i_sleep <= 1'b0;
        rd(GST_OFF_GCTRL, v0);
        chk("gate level", 8'h04, v0 & 8'h04);
        // byte timer wrap pulses the gate, its fall sets the event flag;
        // select first, since the switch itself drops the gate level
        wr(GST_OFF_GCTRL, 8'h41);
        wr(GST_OFF_FLAGS, 8'h03);
        repeat (300) @(posedge i_sys_clk);
        rd(GST_OFF_FLAGS, v0);
        chk("wrap event", 8'h02, v0 & 8'h02);
        // single pulse: counter stopped before count writes
        wr(GST_OFF_TCTRL, 8'h40);
        wr(GST_OFF_CNT_LO, 8'h00);
        wr(GST_OFF_CNT_HI, 8'h00);
        wr(GST_OFF_FLAGS, 8'h03);
        wr(GST_OFF_IRQ_EN, 8'h02);
        gate <= 1'b0;
        wr(GST_OFF_GCTRL, 8'hd0);
        wr(GST_OFF_GCTRL, 8'hd8);
        wr(GST_OFF_TCTRL, 8'h41);
        repeat (2) begin
            repeat (8) @(posedge i_sys_clk);
            gate <= 1'b1;
            repeat (20) @(posedge i_sys_clk);
            gate <= 1'b0;
            repeat (8) @(posedge i_sys_clk);
            rd(GST_OFF_CNT_LO, v0);
            chk("pulse count", 8'h14, v0);
        end
        rd(GST_OFF_GCTRL, v0);
        chk("go cleared", 8'h00, v0 & 8'h08);
        chk("gate irq", 8'h01, {7'h0, o_gate_irq});
        wr(GST_OFF_GCTRL, 8'hc0);
        // toggle with single pulse spans one whole gate period, polarity kept
        wr(GST_OFF_TCTRL, 8'h40);
        wr(GST_OFF_CNT_LO, 8'h00);
        wr(GST_OFF_GCTRL, 8'hf0);
        wr(GST_OFF_GCTRL, 8'hf8);
        wr(GST_OFF_TCTRL, 8'h41);
        repeat (3) begin
            gate <= 1'b1;
            repeat (10) @(posedge i_sys_clk);
            gate <= 1'b0;
            repeat (10) @(posedge i_sys_clk);
        end
        rd(GST_OFF_CNT_LO, v0);
        chk("period count", 8'h14, v0);
        // rollover from a value just short of the top
        wr(GST_OFF_TCTRL, 8'h40);
        wr(GST_OFF_CNT_LO, 8'hf0);
        wr(GST_OFF_CNT_HI, 8'hff);
        wr(GST_OFF_FLAGS, 8'h03);
        wr(GST_OFF_IRQ_EN, 8'h01);
        wr(GST_OFF_GCTRL, 8'h00);
        i_peripheral_irq_enable <= 1'b1;
        i_global_irq_enable <= 1'b1;
        wr(GST_OFF_TCTRL, 8'h41);
        repeat (30) @(posedge i_sys_clk);
        rd(GST_OFF_CNT_HI, v0);
        chk("count high", 8'h00, v0);
        rd(GST_OFF_FLAGS, v0);
        chk("overflow flag", 8'h01, v0 & 8'h01);
        chk("ovf irq", 8'h01, {7'h0, o_overflow_irq});
        @(posedge i_sys_clk);
        i_sleep <= 1'b1;
        i_global_irq_enable <= 1'b0;
        @(posedge i_sys_clk);
        #1 chk("ovf irq gie", 8'h00, {7'h0, o_overflow_irq});
        chk("wake", 8'h01, {7'h0, o_wake});
        wr(GST_OFF_FLAGS, 8'h01);
        @(posedge i_sys_clk);
        #1 chk("wake cleared", 8'h00, {7'h0, o_wake});
        end_sim;
    end
endmodule
